//--- kpd_mode_ctrl.sv
// Front-panel mode controller: keypad events in, five seven-segment digits out,
// with parameter store, monitor values and alarm source on the drive side.
// Assumes all drive-side inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`include "kpd_map.svh"

module kpd_mode_ctrl #(
    parameter int MSG_CYC   = `KPD_CYC(`KPD_MSG_MS),
    parameter int IDLE_CYC  = `KPD_CYC(`KPD_IDLE_MS),
    parameter int HOLD_CYC  = `KPD_CYC(`KPD_HOLD_MS),
    parameter int DEB_CYC   = `KPD_CYC(`KPD_DEB_MS),
    parameter int BLINK_CYC = `KPD_CYC(`KPD_BLINK_MS)
) (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic [`KPD_NUM_KEYS-1:0] key_pin_n,
    input  wire logic                     alarm_active,
    input  wire logic [11:0]              alarm_code,
    input  wire logic [4:0]               mon_item_dflt,
    input  wire logic [19:0]              mon_dec_lo,
    input  wire logic [19:0]              mon_dec_hi,
    input  wire logic [15:0]              mon_hex_lo,
    input  wire logic [15:0]              mon_hex_hi,
    input  wire logic                     mon_neg,
    input  wire logic                     mon_is32,
    input  wire logic [19:0]              param_rd_digits,
    input  wire logic                     param_rd_neg,
    input  wire logic                     param_rd_hex,
    input  wire logic                     param_neg_ok,
    input  wire logic                     param_wr_ack,
    input  wire kpd_pkg::kpd_wstat_t      param_wr_status,
    input  wire logic                     diag_active,
    input  wire logic                     diag_last_step,
    output logic [4:0]                    mon_item_q,
    output logic [3:0]                    param_group_q,
    output logic [7:0]                    param_index_q,
    output logic                          param_wr_req_q,
    output logic [19:0]                   param_wr_digits_q,
    output logic                          param_wr_neg_q,
    output logic                          diag_exec_q,
    output logic [34:0]                   seg_q,
    output logic [4:0]                    dp_q
);

    kpd_key_if keys ();

    kpd_key_debounce #(
        .DEB_CYC (DEB_CYC)
    ) u_debounce (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .key_pin_n (key_pin_n),
        .keys      (keys)
    );

    kpd_pkg::kpd_state_t state_q, state_d;
    kpd_pkg::kpd_wstat_t wstat_q, wstat_d;
    logic        init_q,     init_d;
    logic        alarm_q,    alarm_d;
    logic [31:0] timer_q,    timer_d;
    logic [31:0] idle_q,     idle_d;
    logic [31:0] hold_q,     hold_d;
    logic        hold_done_q, hold_done_d;
    logic [31:0] blink_q,    blink_d;
    logic        blink_on_q, blink_on_d;
    logic [4:0]  mon_item_d;
    logic        hex_q,      hex_d;
    logic        hi_q,       hi_d;
    logic [3:0]  group_d;
    logic [7:0]  index_d;
    logic [19:0] edit_d;
    logic        neg_d;
    logic        edit_hex_q, edit_hex_d;
    logic [2:0]  cur_q,      cur_d;
    logic        wr_req_d;
    logic        diag_d;

    logic        k_mode;
    logic        k_shift;
    logic        k_up;
    logic        k_down;
    logic        k_set;
    logic [3:0]  dig;
    logic [3:0]  dig_last;

    assign k_mode  = keys.press[`KPD_K_MODE];
    assign k_shift = keys.press[`KPD_K_SHIFT];
    assign k_up    = keys.press[`KPD_K_UP];
    assign k_down  = keys.press[`KPD_K_DOWN];
    assign k_set   = keys.press[`KPD_K_SET];
    assign dig      = param_wr_digits_q[cur_q*4 +: 4];
    assign dig_last = edit_hex_q ? 4'hf : `KPD_DEC_LAST;

    always_comb begin
        state_d     = state_q;
        wstat_d     = wstat_q;
        init_d      = 1'b1;
        alarm_d     = alarm_active;
        timer_d     = (timer_q != 32'h0) ? timer_q - 32'h1 : 32'h0;
        idle_d      = (idle_q >= 32'(IDLE_CYC)) ? idle_q : idle_q + 32'h1;
        hold_d      = 32'h0;
        hold_done_d = 1'b0;
        blink_d     = blink_q + 32'h1;
        blink_on_d  = blink_on_q;
        mon_item_d  = mon_item_q;
        hex_d       = hex_q;
        hi_d        = hi_q;
        group_d     = param_group_q;
        index_d     = param_index_q;
        edit_d      = param_wr_digits_q;
        neg_d       = param_wr_neg_q;
        edit_hex_d  = edit_hex_q;
        cur_d       = cur_q;
        wr_req_d    = 1'b0;
        diag_d      = 1'b0;
        if (blink_q >= 32'(BLINK_CYC - 1)) begin
            blink_d    = 32'h0;
            blink_on_d = ~blink_on_q;
        end
        if (|keys.press) begin
            idle_d = 32'h0;
        end
        unique case (state_q)
            kpd_pkg::KS_POWERUP: begin
                if (!init_q) begin
                    mon_item_d = mon_item_dflt;
                end else if (timer_q == 32'h0) begin
                    state_d = kpd_pkg::KS_MONITOR;
                end
            end
            kpd_pkg::KS_MONITOR: begin
                if (k_mode) begin
                    state_d = kpd_pkg::KS_PARAM;
                    timer_d = 32'h0;
                end else if (k_up || k_down) begin
                    if (k_up) begin
                        mon_item_d = (mon_item_q == `KPD_MON_LAST) ? 5'h0 : mon_item_q + 5'h1;
                    end else begin
                        mon_item_d = (mon_item_q == 5'h0) ? `KPD_MON_LAST : mon_item_q - 5'h1;
                    end
                    timer_d = 32'(MSG_CYC);
                end else if (k_set) begin
                    hex_d = ~hex_q;
                end else if (k_shift) begin
                    hi_d = ~hi_q;
                end
            end
            kpd_pkg::KS_PARAM: begin
                if (k_mode) begin
                    state_d = kpd_pkg::KS_MONITOR;
                end else if (k_shift) begin
                    group_d = (param_group_q == `KPD_GRP_LAST) ? 4'h0 : param_group_q + 4'h1;
                    index_d = 8'h0;
                end else if (k_up) begin
                    index_d = (param_index_q == `KPD_IDX_LAST) ? 8'h0 : param_index_q + 8'h1;
                end else if (k_down) begin
                    index_d = (param_index_q == 8'h0) ? `KPD_IDX_LAST : param_index_q - 8'h1;
                end else if (k_set) begin
                    state_d    = kpd_pkg::KS_SETTING;
                    edit_d     = param_rd_digits;
                    neg_d      = param_rd_neg & ~param_rd_hex;
                    edit_hex_d = param_rd_hex;
                    cur_d      = 3'h0;
                end
            end
            kpd_pkg::KS_SETTING: begin
                if (k_mode) begin
                    state_d = kpd_pkg::KS_PARAM;
                end else if (k_shift) begin
                    cur_d = (cur_q == `KPD_CUR_LAST) ? 3'h0 : cur_q + 3'h1;
                end else if (k_up) begin
                    edit_d[cur_q*4 +: 4] = (dig >= dig_last) ? 4'h0 : dig + 4'h1;
                end else if (k_down) begin
                    edit_d[cur_q*4 +: 4] = (dig == 4'h0) ? dig_last : dig - 4'h1;
                end else if (k_set) begin
                    if (diag_active) begin
                        diag_d = diag_last_step;
                    end else begin
                        wr_req_d = 1'b1;
                        state_d  = kpd_pkg::KS_WAIT;
                    end
                end
                // A long hold flips the sign of a decimal value once, if negative is allowed or already set; the press itself still moved the cursor
                if (keys.held[`KPD_K_SHIFT]) begin
                    hold_done_d = hold_done_q;
                    hold_d      = (hold_q >= 32'(HOLD_CYC)) ? hold_q : hold_q + 32'h1;
                    if (hold_q >= 32'(HOLD_CYC - 1) && !hold_done_q) begin
                        hold_done_d = 1'b1;
                        if (!edit_hex_q && (param_wr_neg_q || param_neg_ok)) begin
                            neg_d = ~param_wr_neg_q;
                        end
                    end
                end
            end
            kpd_pkg::KS_WAIT: begin
                if (param_wr_ack) begin
                    wstat_d = param_wr_status;
                    timer_d = 32'(MSG_CYC);
                    state_d = kpd_pkg::KS_STATUS;
                end
            end
            kpd_pkg::KS_STATUS: begin
                if (timer_q == 32'h0) begin
                    state_d = kpd_pkg::KS_PARAM;
                end
            end
            kpd_pkg::KS_FAULT: begin
                if (k_mode) begin
                    state_d = kpd_pkg::KS_MONITOR;
                end
            end
        endcase
        if (alarm_active && !alarm_q) begin
            state_d = kpd_pkg::KS_FAULT;
            timer_d = 32'h0;
        end else if (alarm_active && state_q != kpd_pkg::KS_FAULT
                     && state_q != kpd_pkg::KS_POWERUP && idle_q >= 32'(IDLE_CYC)) begin
            state_d = kpd_pkg::KS_FAULT;
            timer_d = 32'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q           <= kpd_pkg::KS_POWERUP;
            wstat_q           <= kpd_pkg::WS_SAVED;
            init_q            <= 1'b0;
            alarm_q           <= 1'b0;
            timer_q           <= 32'(MSG_CYC);
            idle_q            <= 32'h0;
            hold_q            <= 32'h0;
            hold_done_q       <= 1'b0;
            blink_q           <= 32'h0;
            blink_on_q        <= 1'b1;
            mon_item_q        <= 5'h0;
            hex_q             <= 1'b0;
            hi_q              <= 1'b0;
            param_group_q     <= 4'h0;
            param_index_q     <= 8'h0;
            param_wr_digits_q <= 20'h0;
            param_wr_neg_q    <= 1'b0;
            edit_hex_q        <= 1'b0;
            cur_q             <= 3'h0;
            param_wr_req_q    <= 1'b0;
            diag_exec_q       <= 1'b0;
        end else begin
            state_q           <= state_d;
            wstat_q           <= wstat_d;
            init_q            <= init_d;
            alarm_q           <= alarm_d;
            timer_q           <= timer_d;
            idle_q            <= idle_d;
            hold_q            <= hold_d;
            hold_done_q       <= hold_done_d;
            blink_q           <= blink_d;
            blink_on_q        <= blink_on_d;
            mon_item_q        <= mon_item_d;
            hex_q             <= hex_d;
            hi_q              <= hi_d;
            param_group_q     <= group_d;
            param_index_q     <= index_d;
            param_wr_digits_q <= edit_d;
            param_wr_neg_q    <= neg_d;
            edit_hex_q        <= edit_hex_d;
            cur_q             <= cur_d;
            param_wr_req_q    <= wr_req_d;
            diag_exec_q       <= diag_d;
        end
    end

    function automatic logic [6:0] kpd_seg(input kpd_pkg::kpd_glyph_t g);
        unique case (g)
            5'h00: kpd_seg = 7'h3f;
            5'h01: kpd_seg = 7'h06;
            5'h02: kpd_seg = 7'h5b;
            5'h03: kpd_seg = 7'h4f;
            5'h04: kpd_seg = 7'h66;
            5'h05: kpd_seg = 7'h6d;
            5'h06: kpd_seg = 7'h7d;
            5'h07: kpd_seg = 7'h07;
            5'h08: kpd_seg = 7'h7f;
            5'h09: kpd_seg = 7'h6f;
            5'h0a: kpd_seg = 7'h77;
            5'h0b: kpd_seg = 7'h7c;
            5'h0c: kpd_seg = 7'h39;
            5'h0d: kpd_seg = 7'h5e;
            5'h0e: kpd_seg = 7'h79;
            5'h0f: kpd_seg = 7'h71;
            `KPD_G_MIN: kpd_seg = 7'h40;
            `KPD_G_L:   kpd_seg = 7'h38;
            `KPD_G_R:   kpd_seg = 7'h50;
            `KPD_G_U:   kpd_seg = 7'h3e;
            `KPD_G_N:   kpd_seg = 7'h54;
            `KPD_G_O:   kpd_seg = 7'h5c;
            `KPD_G_P:   kpd_seg = 7'h73;
            `KPD_G_T:   kpd_seg = 7'h78;
            `KPD_G_Y:   kpd_seg = 7'h6e;
            default:    kpd_seg = 7'h00;
        endcase
    endfunction

    kpd_pkg::kpd_glyph_t gl [5];
    logic [4:0]  dp_d;
    logic [34:0] seg_d;
    logic [19:0] mon_dec;

    assign mon_dec = (mon_is32 && hi_q) ? mon_dec_hi : mon_dec_lo;

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            gl[i] = `KPD_G_BL;
        end
        dp_d = 5'h0;
        unique case (state_q)
            kpd_pkg::KS_POWERUP, kpd_pkg::KS_MONITOR: begin
                if (state_q == kpd_pkg::KS_POWERUP || timer_q != 32'h0) begin
                    gl[4] = 5'h0f;
                    gl[3] = `KPD_G_N;
                    gl[2] = `KPD_G_MIN;
                    gl[1] = {4'h0, mon_item_q[4]};
                    gl[0] = {1'b0, mon_item_q[3:0]};
                end else if (hex_q) begin
                    for (int i = 0; i < 4; i++) begin
                        gl[i] = {1'b0, hi_q ? mon_hex_hi[i*4 +: 4] : mon_hex_lo[i*4 +: 4]};
                    end
                end else begin
                    for (int i = 0; i < 5; i++) begin
                        gl[i] = {1'b0, mon_dec[i*4 +: 4]};
                    end
                    dp_d[4:3] = {2{mon_neg}};
                    dp_d[1:0] = mon_is32 ? {hi_q, ~hi_q} : 2'b00;
                end
            end
            kpd_pkg::KS_PARAM: begin
                gl[4] = `KPD_G_P;
                gl[3] = {1'b0, param_group_q};
                gl[2] = `KPD_G_MIN;
                gl[1] = {1'b0, param_index_q[7:4]};
                gl[0] = {1'b0, param_index_q[3:0]};
            end
            kpd_pkg::KS_SETTING, kpd_pkg::KS_WAIT: begin
                for (int i = 0; i < 5; i++) begin
                    gl[i] = {1'b0, param_wr_digits_q[i*4 +: 4]};
                end
                if (state_q == kpd_pkg::KS_SETTING && !blink_on_q) begin
                    gl[cur_q] = `KPD_G_BL;
                end
                dp_d[4:3] = {2{param_wr_neg_q & ~edit_hex_q}};
            end
            kpd_pkg::KS_STATUS: begin
                unique case (wstat_q)
                    kpd_pkg::WS_SAVED:
                        {gl[4], gl[3], gl[2], gl[1], gl[0]} =
                            {5'h05, 5'h0a, `KPD_G_U, 5'h0e, 5'h0d};
                    kpd_pkg::WS_READ_ONLY:
                        {gl[4], gl[3], gl[2], gl[1], gl[0]} =
                            {`KPD_G_R, `KPD_G_MIN, 5'h00, `KPD_G_L, `KPD_G_Y};
                    kpd_pkg::WS_LOCKED:
                        {gl[4], gl[3], gl[2], gl[1], gl[0]} =
                            {`KPD_G_L, `KPD_G_O, 5'h0c, 5'h0e, 5'h0d};
                    kpd_pkg::WS_RANGE:
                        {gl[4], gl[3], gl[2], gl[1], gl[0]} =
                            {5'h00, `KPD_G_U, `KPD_G_T, `KPD_G_MIN, `KPD_G_R};
                    kpd_pkg::WS_SERVO_ON:
                        {gl[4], gl[3], gl[2], gl[1], gl[0]} =
                            {5'h05, `KPD_G_R, `KPD_G_MIN, `KPD_G_O, `KPD_G_N};
                    default:
                        {gl[4], gl[3], gl[2], gl[1], gl[0]} =
                            {`KPD_G_P, `KPD_G_O, `KPD_G_MIN, `KPD_G_O, `KPD_G_N};
                endcase
            end
            kpd_pkg::KS_FAULT: begin
                gl[4] = 5'h0a;
                gl[3] = `KPD_G_L;
                gl[2] = {1'b0, alarm_code[11:8]};
                gl[1] = {1'b0, alarm_code[7:4]};
                gl[0] = {1'b0, alarm_code[3:0]};
            end
        endcase
    end

    for (genvar i = 0; i < 5; i++) begin : g_digit
        assign seg_d[i*7 +: 7] = kpd_seg(gl[i]);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            seg_q <= 35'h0;
            dp_q  <= 5'h0;
        end else begin
            seg_q <= seg_d;
            dp_q  <= dp_d;
        end
    end

endmodule

//--- kpd_map.svh
// Constants of the keypad and display mode controller: key indices, timing,
// glyph codes and value ranges. Assumes a 40 MHz system clock.
`ifndef KPD_MAP_SVH
`define KPD_MAP_SVH

`define KPD_CLK_HZ      40000000
`define KPD_CYC(ms)     ((ms) * (`KPD_CLK_HZ / 1000))

// Times in milliseconds
`define KPD_MSG_MS      1000
`define KPD_IDLE_MS     20000
`define KPD_HOLD_MS     2000
`define KPD_DEB_MS      10
`define KPD_BLINK_MS    250

`define KPD_NUM_KEYS    5
`define KPD_K_MODE      0
`define KPD_K_SHIFT     1
`define KPD_K_UP        2
`define KPD_K_DOWN      3
`define KPD_K_SET       4

`define KPD_MON_LAST    5'h12
`define KPD_GRP_LAST    4'h4
`define KPD_IDX_LAST    8'h63
`define KPD_CUR_LAST    3'h4
`define KPD_DEC_LAST    4'h9

// Glyph codes; 5'h00 to 5'h0f are the hex digits themselves
`define KPD_G_BL        5'h10
`define KPD_G_MIN       5'h11
`define KPD_G_L         5'h12
`define KPD_G_R         5'h13
`define KPD_G_U         5'h14
`define KPD_G_N         5'h15
`define KPD_G_O         5'h16
`define KPD_G_P         5'h17
`define KPD_G_T         5'h18
`define KPD_G_Y         5'h19

`endif

//--- kpd_pkg.sv
// Types shared by the keypad and display mode controller.
// Assumes kpd_map.svh holds all numeric constants.
package kpd_pkg;

    typedef enum logic [2:0] {
        WS_SAVED,
        WS_READ_ONLY,
        WS_LOCKED,
        WS_RANGE,
        WS_SERVO_ON,
        WS_RESTART
    } kpd_wstat_t;

    typedef enum logic [2:0] {
        KS_POWERUP,
        KS_MONITOR,
        KS_PARAM,
        KS_SETTING,
        KS_WAIT,
        KS_STATUS,
        KS_FAULT
    } kpd_state_t;

    typedef logic [4:0] kpd_glyph_t;

endpackage

//--- kpd_key_if.sv
// Debounced key events between the key conditioner and the mode controller.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`include "kpd_map.svh"

interface kpd_key_if;
    logic [`KPD_NUM_KEYS-1:0] press;
    logic [`KPD_NUM_KEYS-1:0] held;

    modport src (output press, output held);
    modport dst (input press, input held);
endinterface

//--- kpd_key_debounce.sv
// Key conditioner: synchronises the active-low key pins, debounces them and
// emits one pulse per press. Assumes pins are asynchronous to clk_sys.
`timescale 1ns/1ps
`include "kpd_map.svh"

module kpd_key_debounce #(
    parameter int DEB_CYC = `KPD_CYC(`KPD_DEB_MS)
) (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic [`KPD_NUM_KEYS-1:0] key_pin_n,
    kpd_key_if.src                        keys
);

    for (genvar i = 0; i < `KPD_NUM_KEYS; i++) begin : g_key
        logic        s1_q;
        logic        s2_q;
        logic        stable_q;
        logic        stable_d;
        logic        press_q;
        logic        press_d;
        logic [31:0] cnt_q;
        logic [31:0] cnt_d;

        // A level must hold for the full window before it counts
        always_comb begin
            stable_d = stable_q;
            press_d  = 1'b0;
            cnt_d    = 32'h0;
            if (s2_q != stable_q) begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= 32'(DEB_CYC - 1)) begin
                    stable_d = s2_q;
                    press_d  = s2_q;
                    cnt_d    = 32'h0;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                s1_q     <= 1'b0;
                s2_q     <= 1'b0;
                stable_q <= 1'b0;
                press_q  <= 1'b0;
                cnt_q    <= 32'h0;
            end else begin
                s1_q     <= ~key_pin_n[i];
                s2_q     <= s1_q;
                stable_q <= stable_d;
                press_q  <= press_d;
                cnt_q    <= cnt_d;
            end
        end

        assign keys.press[i] = press_q;
        assign keys.held[i]  = stable_q;
    end

endmodule

//--- kpd_mode_ctrl_checker.sv
// Port checker for kpd_mode_ctrl.
// Assumes every watched port is synchronous to clk_sys; bound below.
`timescale 1ns/1ps
module kpd_mode_ctrl_checker (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        alarm_active,
    input wire logic [4:0]  mon_item_dflt,
    input wire logic        param_wr_ack,
    input wire kpd_pkg::kpd_wstat_t param_wr_status,
    input wire logic        diag_active,
    input wire logic [4:0]  mon_item_q,
    input wire logic        param_wr_req_q,
    input wire logic        diag_exec_q,
    input wire logic [34:0] seg_q,
    input wire logic [4:0]  dp_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Leftmost two digits spell the alarm prefix
    sequence s_alarm_prefix; seg_q[34:21] == {7'h77, 7'h38}; endsequence
    sequence s_ack_seen; param_wr_ack ##3 1'b1; endsequence
    property p_pwr; $fell(sys_rst) |=> mon_item_q == $past(mon_item_dflt); endproperty
    a_pwr: assert property (p_pwr) else $error("power-up item");
    property p_fault; $rose(alarm_active) |-> ##2 s_alarm_prefix; endproperty
    a_fault: assert property (p_fault) else $error("no fault display");
    property p_wr; param_wr_req_q |=> !param_wr_req_q; endproperty
    a_wr: assert property (p_wr) else $error("commit not a pulse");
    property p_exec; diag_exec_q |-> diag_active && !param_wr_req_q ##1 !diag_exec_q; endproperty
    a_exec: assert property (p_exec) else $error("diag execute");
    property p_saved;
        param_wr_ack && param_wr_status == kpd_pkg::WS_SAVED |-> ##2 seg_q[34:28] == 7'h6d;
    endproperty
    a_saved: assert property (p_saved) else $error("saved message");
    property p_msg; s_ack_seen |-> $stable(seg_q) [*8]; endproperty
    a_msg: assert property (p_msg) else $error("status message");
    property p_sign; dp_q[4] == dp_q[3]; endproperty
    a_sign: assert property (p_sign) else $error("sign points");
    property p_hilo; !(dp_q[1] && dp_q[0]); endproperty
    a_hilo: assert property (p_hilo) else $error("high and low");
endmodule
bind kpd_mode_ctrl kpd_mode_ctrl_checker u_chk (.*);

//--- kpd_operator.sv
// Operator model: presses active-low keys with contact bounce.
// Assumes the caller waits for each press to finish.
`timescale 1ns/1ps
module kpd_operator (
    input  wire logic       clk_sys,
    output logic      [4:0] key_pin_n
);
    initial key_pin_n = 5'h1f;
    task automatic press(input int k, input int hold);
        repeat (2) begin
            @(posedge clk_sys) key_pin_n[k] <= 1'b0;
            @(posedge clk_sys) key_pin_n[k] <= 1'b1;
        end
        @(posedge clk_sys) key_pin_n[k] <= 1'b0;
        repeat (hold) @(posedge clk_sys);
        key_pin_n[k] <= 1'b1;
        repeat (20) @(posedge clk_sys);
    endtask
endmodule

//--- tb.sv
// Self-checking bench for kpd_mode_ctrl, short timing parameters.
// Assumes kpd_operator presses keys; bench acts as store and alarm source.
`timescale 1ns/1ps
`include "kpd_map.svh"
module tb;
    localparam int MSG = 50;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, alarm_active = 1'b0;
    logic        param_rd_neg = 1'b0, param_wr_ack = 1'b0, diag_active = 1'b0;
    logic        param_wr_req_q, param_wr_neg_q, diag_exec_q;
    logic        param_rd_hex = 1'b0, diag_last_step = 1'b0;
    logic [4:0]  key_pin_n, mon_item_q, last_mon, dp_q;
    logic [3:0]  param_group_q;
    logic [7:0]  param_index_q;
    logic [34:0] seg_q;
    logic [19:0] param_wr_digits_q;
    logic [31:0] rnd = 32'hb1a1;
    logic [3:0]  ack_dly = 4'h0;
    logic [20:0] exp_mon[$], exp_wr[$], diag_n = 21'h0;
    int          cyc = 0, mismatches = 0, check_count = 0;
    kpd_pkg::kpd_wstat_t param_wr_status = kpd_pkg::WS_SAVED;
    always #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [20:0] got, input logic [20:0] e);
        check_count++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic chk_mon(input logic [4:0] got);
        cmp({16'h0, got}, exp_mon.size() > 0 ? exp_mon.pop_front() : 21'h1fffff);
    endtask
    task automatic chk_wr(input logic [20:0] got);
        cmp(got, exp_wr.size() > 0 ? exp_wr.pop_front() : 21'h1fffff);
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    kpd_operator u_kpd_operator (.clk_sys, .key_pin_n);
    kpd_mode_ctrl #(.MSG_CYC(MSG), .IDLE_CYC(400), .HOLD_CYC(100), .DEB_CYC(4), .BLINK_CYC(8))
        u_kpd_mode_ctrl (.*, .alarm_code(rnd[11:0]), .mon_item_dflt(5'h12),
        .mon_dec_lo(rnd[19:0]), .mon_dec_hi(rnd[31:12]), .mon_hex_lo(rnd[15:0]),
        .mon_hex_hi(rnd[31:16]), .mon_neg(rnd[3]), .mon_is32(rnd[7]), .param_neg_ok(1'b1),
        .param_rd_digits(20'h12349));
    // Store answers each commit seven cycles later
    always @(posedge clk_sys) begin
        rnd <= lfsr(rnd);
        cyc <= cyc + 1;
        last_mon <= mon_item_q;
        if (diag_exec_q === 1'b1) diag_n <= diag_n + 21'h1;
        param_wr_ack <= (ack_dly == 4'h1);
        if (param_wr_req_q === 1'b1) ack_dly <= 4'h6;
        else if (ack_dly != 4'h0) ack_dly <= ack_dly - 4'h1;
        if (!sys_rst && mon_item_q !== last_mon) chk_mon(mon_item_q);
        if (param_wr_req_q === 1'b1) chk_wr({param_wr_neg_q, param_wr_digits_q});
        if (cyc == 10000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        param_rd_neg <= rnd[0];
        exp_mon.push_back(21'h12);
        repeat (MSG + 20) @(posedge clk_sys);
        exp_mon.push_back(21'h00);
        u_kpd_operator.press(`KPD_K_UP, 10);
        exp_mon.push_back(21'h12);
        u_kpd_operator.press(`KPD_K_DOWN, 10);
        u_kpd_operator.press(`KPD_K_SET, 10);
        u_kpd_operator.press(`KPD_K_MODE, 10);
        u_kpd_operator.press(`KPD_K_SHIFT, 10);
        u_kpd_operator.press(`KPD_K_DOWN, 10);
        cmp({9'h0, param_group_q, param_index_q}, {9'h0, 4'h1, 8'h63});
        for (int s = 0; s < 6; s++) begin
            param_wr_status <= kpd_pkg::kpd_wstat_t'(s);
            // Second pass edits a hex parameter: digit range to f, no sign flip
            param_rd_hex <= (s == 1);
            u_kpd_operator.press(`KPD_K_SET, 10);
            if (s < 2) begin
                u_kpd_operator.press(`KPD_K_UP, 10);
                u_kpd_operator.press(`KPD_K_SHIFT, 130);
                u_kpd_operator.press(`KPD_K_UP, 10);
                if (s == 0) exp_wr.push_back({~param_rd_neg, 20'h12350});
                else exp_wr.push_back({1'b0, 20'h1235a});
            end else
                exp_wr.push_back({param_rd_neg, 20'h12349});
            u_kpd_operator.press(`KPD_K_SET, 10);
            repeat (MSG + 20) @(posedge clk_sys);
        end
        u_kpd_operator.press(`KPD_K_SET, 10);
        u_kpd_operator.press(`KPD_K_UP, 10);
        u_kpd_operator.press(`KPD_K_MODE, 10);
        diag_active <= 1'b1;
        u_kpd_operator.press(`KPD_K_SET, 10);
        u_kpd_operator.press(`KPD_K_SET, 10);
        diag_last_step <= 1'b1;
        u_kpd_operator.press(`KPD_K_SET, 10);
        u_kpd_operator.press(`KPD_K_MODE, 10);
        cmp(diag_n, 21'h1);
        diag_active <= 1'b0;
        alarm_active <= 1'b1;
        repeat (5) @(posedge clk_sys);
        u_kpd_operator.press(`KPD_K_MODE, 10);
        cmp({14'h0, seg_q[34:28]}, 21'h0);
        repeat (450) @(posedge clk_sys);
        cmp({7'h0, seg_q[34:21]}, {7'h0, 7'h77, 7'h38});
        end_of_test();
    end
endmodule
